//--- rtl/obcd_pkg.sv
package obcd_pkg;

	// ************************************************************
	// Configuration byte layout
	// ************************************************************
	localparam int unsigned  CLKSRC_HI   = 7;   // Startup clock field, upper bit
	localparam int unsigned  CLKSRC_LO   = 6;   // Startup clock field, lower bit
	localparam int unsigned  DET_BIT     = 2;   // Detector enable, active low
	localparam int unsigned  WDT_BIT     = 1;   // Watchdog type
	localparam int unsigned  WDH_BIT     = 0;   // Reset on Halt
	localparam int unsigned  AWK_BIT     = 7;   // Wake-up clock select
	localparam int unsigned  RNG_HI      = 6;   // Oscillator range field, upper bit
	localparam int unsigned  RNG_LO      = 4;   // Oscillator range field, lower bit
	localparam int unsigned  SSZ_HI      = 3;   // Sector 0 size field, upper bit
	localparam int unsigned  SSZ_LO      = 2;   // Sector 0 size field, lower bit
	localparam int unsigned  RDP_BIT     = 1;   // Read-out protection
	localparam int unsigned  WRP_BIT     = 0;   // Write protection

	// Erased (default) values of the two bytes
	localparam logic [7:0]   CFG0_ERASED = 8'h_00FC;
	localparam logic [7:0]   CFG1_ERASED = 8'h_003F;
	// Content of unprogrammed program memory
	localparam logic [7:0]   PM_ERASED   = 8'h_00FF;
	// Smallest sector 0 size in bytes
	localparam logic [12:0]  SEC0_BASE   = 13'h_0200;
	// Range code used with the very-low-power oscillator
	localparam logic [2:0]   RNG_SLOW    = 3'h_4;
	// Byte addresses of the two configuration bytes
	localparam logic         ADDR_CFG0   = 1'h_0;
	localparam logic         ADDR_CFG1   = 1'h_1;

	// ************************************************************
	// Codes
	// ************************************************************
	// Startup clock sources
	typedef enum logic [1:0] {
		OBCD_CK_RC   = 2'h_0,
		OBCD_CK_WURC = 2'h_1,
		OBCD_CK_XTAL = 2'h_2,
		OBCD_CK_EXT  = 2'h_3
	} obcd_clk_t;

	// Commands of the programming interface
	typedef enum logic [2:0] {
		OBCD_OP_CFG_RD = 3'h_0,
		OBCD_OP_CFG_WR = 3'h_1,
		OBCD_OP_CFG_ER = 3'h_2,
		OBCD_OP_PM_RD  = 3'h_3,
		OBCD_OP_PM_WR  = 3'h_4,
		OBCD_OP_PM_ER  = 3'h_5
	} obcd_op_t;

	// Erase sequencer states, one-hot
	typedef enum logic [3:0] {
		OBCD_SQ_IDLE = 4'h_1,
		OBCD_SQ_MASS = 4'h_2,
		OBCD_SQ_WR0  = 4'h_4,
		OBCD_SQ_WR1  = 4'h_8
	} obcd_state_t;

	// ************************************************************
	// Carriers
	// ************************************************************
	// Command from the programming interface
	typedef struct packed {
		logic        valid;  // One-cycle request
		obcd_op_t    op;     // Operation
		logic        addr;   // Configuration byte select
		logic [7:0]  data;   // Write data
	} obcd_cmd_t;

	// Answer to a command
	typedef struct packed {
		logic        ack;     // Done pulse
		logic        refused; // Refused pulse
		logic [7:0]  rdata;   // Read data
	} obcd_rsp_t;

	// Write request toward the nonvolatile bytes
	typedef struct packed {
		logic        wr;
		logic        addr;
		logic [7:0]  data;
	} obcd_nvw_t;

	// Program memory permissions
	typedef struct packed {
		logic        rd_ok;    // Read grant pulse
		logic        wr_ok;    // Program grant pulse
		logic        er_ok;    // Erase grant pulse
		logic        mass_er;  // Whole-memory erase request pulse
		logic [7:0]  fill;     // Value an erase leaves behind
	} obcd_pm_t;

	// Decoded static settings
	typedef struct packed {
		obcd_clk_t   startup_clock_select;
		logic        resonator_range_used;
		logic [2:0]  oscillator_range_field;
		logic        wakeup_clock_select;
		logic        low_voltage_detector_enable_n;
		logic        watchdog_type_select;
		logic        watchdog_hw_enable;
		logic        watchdog_halt_reset_select;
		logic [1:0]  sector0_size_field;
		logic [12:0] sector0_bytes;
		logic        read_protect_bit;
		logic        write_protect_bit;
	} obcd_set_t;

endpackage : obcd_pkg

//--- rtl/obcd_config_decoder.sv
`timescale 1ns/10ps
// Contract
// R1: Byte one 7:6 selects startup clock
// R2: Tool writes ones to reserved bits
// R3: Byte one bit2 low enables detector
// R4: Byte one bit1 low forces watchdog
// R5: Byte one bit0 high resets on Halt
// R6: Byte zero bit7 picks wake-up clock
// R7: Tool sets range 100 with slow wake clock
// R8: Byte zero 6:4 selects resonator range
// R9: Tool keeps defaults with internal RC (tool model sets range 100 on bit7 low whatever the clock)
// R10: Byte zero 3:2 sets sector 0 size
// R11: Read protect blocks reads and writes
// R12: Config erase under read protect mass-erases
// R13: Byte zero bit0 write-protects memory
// R14: Write protect refuses erase/program forever
// R15: Config access only in programming mode
// R16: Unprogrammed memory reads all ones
// R17: Latch bytes at reset, hold static
// R18: Erased bytes give safe defaults
module obcd_config_decoder (
	input  wire logic               mclk,          // 50 MHz clock
	input  wire logic               rst_n,         // Async reset, active low
	input  wire logic               prog_mode_pin, // Programming mode pin
	input  wire logic [7:0]         nv_byte0,      // Stored configuration byte zero
	input  wire logic [7:0]         nv_byte1,      // Stored configuration byte one
	input  wire logic               mass_done,     // Whole-memory erase finished
	input  wire obcd_pkg::obcd_cmd_t cmd,          // Command from programming logic
	output obcd_pkg::obcd_rsp_t      rsp,          // Answer
	output obcd_pkg::obcd_nvw_t      nvw,          // Write to stored bytes
	output obcd_pkg::obcd_pm_t       pm,           // Program memory permissions
	output obcd_pkg::obcd_set_t      settings      // Decoded settings
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic                  mode_s1;   // Synchroniser first stage
		logic                  mode_s2;   // Synchronised programming mode
		logic                  captured;  // Bytes latched since reset
		obcd_pkg::obcd_state_t sq;        // Erase sequencer
		obcd_pkg::obcd_rsp_t   rsp;
		obcd_pkg::obcd_nvw_t   nvw;
		obcd_pkg::obcd_pm_t    pm;
		obcd_pkg::obcd_set_t   set;
	} obcd_regs_t;

	obcd_regs_t  r;       // Current state
	obcd_regs_t  next_r;  // Next state

	// Sector 0 size in bytes from its field
	function automatic logic [12:0] sect_bytes(input logic [1:0] f);
		sect_bytes = obcd_pkg::SEC0_BASE << f;
	endfunction : sect_bytes

	// Decode of both bytes into settings
	function automatic obcd_pkg::obcd_set_t decode(input logic [7:0] b0, input logic [7:0] b1);
		obcd_pkg::obcd_set_t s;
		s.startup_clock_select = obcd_pkg::obcd_clk_t'(b1[obcd_pkg::CLKSRC_HI:obcd_pkg::CLKSRC_LO]);
		s.resonator_range_used          = b1[obcd_pkg::CLKSRC_HI];
		s.oscillator_range_field        = b0[obcd_pkg::RNG_HI:obcd_pkg::RNG_LO];
		s.wakeup_clock_select           = b0[obcd_pkg::AWK_BIT];
		s.low_voltage_detector_enable_n = b1[obcd_pkg::DET_BIT];
		s.watchdog_type_select          = b1[obcd_pkg::WDT_BIT];
		s.watchdog_hw_enable            = ~b1[obcd_pkg::WDT_BIT];
		s.watchdog_halt_reset_select    = b1[obcd_pkg::WDH_BIT];
		s.sector0_size_field            = b0[obcd_pkg::SSZ_HI:obcd_pkg::SSZ_LO];
		s.sector0_bytes                 = sect_bytes(b0[obcd_pkg::SSZ_HI:obcd_pkg::SSZ_LO]);
		s.read_protect_bit              = b0[obcd_pkg::RDP_BIT];
		s.write_protect_bit             = b0[obcd_pkg::WRP_BIT];
		decode = s;
	endfunction : decode

	// Live protection taken from the stored byte
	logic  live_rdp;  // Read-out protection now stored
	logic  live_wrp;  // Write protection now stored
	assign live_rdp = nv_byte0[obcd_pkg::RDP_BIT];
	assign live_wrp = nv_byte0[obcd_pkg::WRP_BIT];

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		next_r         = r;
		next_r.mode_s1 = prog_mode_pin;
		next_r.mode_s2 = r.mode_s1;
		// Pulses default low
		next_r.rsp.ack     = 1'b0;
		next_r.rsp.refused = 1'b0;
		next_r.nvw.wr      = 1'b0;
		next_r.pm.rd_ok    = 1'b0;
		next_r.pm.wr_ok    = 1'b0;
		next_r.pm.er_ok    = 1'b0;
		next_r.pm.mass_er  = 1'b0;
		next_r.pm.fill     = obcd_pkg::PM_ERASED; // R16
		// First cycle after reset: latch settings once
		if (!r.captured) begin
			next_r.captured = 1'b1;
			next_r.set      = decode(nv_byte0, nv_byte1); // R17 R1 R3 R4 R5 R6 R8 R10 R11 R13
		end
		case (r.sq)
			obcd_pkg::OBCD_SQ_IDLE: begin
				if (cmd.valid) begin
					case (cmd.op)
						obcd_pkg::OBCD_OP_CFG_RD: begin
							if (!r.mode_s2) begin
								next_r.rsp.refused = 1'b1; // R15
							end else begin
								next_r.rsp.ack   = 1'b1;
								next_r.rsp.rdata = (cmd.addr == obcd_pkg::ADDR_CFG1) ?
									nv_byte1 : nv_byte0;
							end
						end
						obcd_pkg::OBCD_OP_CFG_WR: begin
							// Byte zero holds the write-protect bit itself
							if (!r.mode_s2 || (live_wrp && cmd.addr == obcd_pkg::ADDR_CFG0)) begin
								next_r.rsp.refused = 1'b1; // R15 R14
							end else begin
								next_r.nvw.wr   = 1'b1;
								next_r.nvw.addr = cmd.addr;
								next_r.nvw.data = cmd.data;
								next_r.rsp.ack  = 1'b1;
							end
						end
						obcd_pkg::OBCD_OP_CFG_ER: begin
							if (!r.mode_s2 || live_wrp) begin
								next_r.rsp.refused = 1'b1; // R15 R14
							end else if (live_rdp) begin
								next_r.pm.mass_er = 1'b1; // R12
								next_r.sq         = obcd_pkg::OBCD_SQ_MASS;
							end else begin
								next_r.sq = obcd_pkg::OBCD_SQ_WR0;
							end
						end
						obcd_pkg::OBCD_OP_PM_RD: begin
							if (live_rdp) begin
								next_r.rsp.refused = 1'b1; // R11
							end else begin
								next_r.pm.rd_ok = 1'b1;
								next_r.rsp.ack  = 1'b1;
							end
						end
						obcd_pkg::OBCD_OP_PM_WR: begin
							if (live_rdp || live_wrp) begin
								next_r.rsp.refused = 1'b1; // R11 R14
							end else begin
								next_r.pm.wr_ok = 1'b1;
								next_r.rsp.ack  = 1'b1;
							end
						end
						obcd_pkg::OBCD_OP_PM_ER: begin
							if (live_wrp) begin
								next_r.rsp.refused = 1'b1; // R14
							end else begin
								next_r.pm.er_ok = 1'b1;
								next_r.rsp.ack  = 1'b1;
							end
						end
						default: begin
							next_r.rsp.refused = 1'b1;
						end
					endcase
				end
			end
			// Wait for the whole memory to be cleared
			obcd_pkg::OBCD_SQ_MASS: begin
				if (mass_done) begin
					next_r.sq = obcd_pkg::OBCD_SQ_WR0; // R12
				end
			end
			// Restore byte zero to its erased value
			obcd_pkg::OBCD_SQ_WR0: begin
				next_r.nvw.wr   = 1'b1;
				next_r.nvw.addr = obcd_pkg::ADDR_CFG0;
				next_r.nvw.data = obcd_pkg::CFG0_ERASED; // R18
				next_r.sq       = obcd_pkg::OBCD_SQ_WR1;
			end
			// Restore byte one, then finish
			obcd_pkg::OBCD_SQ_WR1: begin
				next_r.nvw.wr   = 1'b1;
				next_r.nvw.addr = obcd_pkg::ADDR_CFG1;
				next_r.nvw.data = obcd_pkg::CFG1_ERASED; // R18
				next_r.rsp.ack  = 1'b1;
				next_r.sq       = obcd_pkg::OBCD_SQ_IDLE;
			end
			default: begin
				next_r.sq = obcd_pkg::OBCD_SQ_IDLE;
			end
		endcase
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r          <= '0;
			r.sq       <= obcd_pkg::OBCD_SQ_IDLE;
			r.pm.fill  <= obcd_pkg::PM_ERASED;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from flip-flops
	assign rsp      = r.rsp;
	assign nvw      = r.nvw;
	assign pm       = r.pm;
	assign settings = r.set;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_cfg_req;
		cmd.valid && r.sq == obcd_pkg::OBCD_SQ_IDLE &&
		(cmd.op == obcd_pkg::OBCD_OP_CFG_RD || cmd.op == obcd_pkg::OBCD_OP_CFG_WR ||
		 cmd.op == obcd_pkg::OBCD_OP_CFG_ER);
	endsequence

	property p_mode_gate;
		s_cfg_req and (!r.mode_s2) |=> rsp.refused && !nvw.wr;
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("config access outside mode"); // R15

	property p_hold;
		r.captured |=> $stable(settings);
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed after latch"); // R17

	// Checked on the edge right after the bytes were latched
	property p_clk;
		$rose(r.captured) |-> settings.startup_clock_select ==
			obcd_pkg::obcd_clk_t'($past(nv_byte1[obcd_pkg::CLKSRC_HI:obcd_pkg::CLKSRC_LO]));
	endproperty
	a_clk: assert property (p_clk) else $error("startup clock decode wrong"); // R1

	// Type bit low forces the watchdog on
	property p_wd;
		$rose(r.captured) |->
			settings.watchdog_type_select == $past(nv_byte1[obcd_pkg::WDT_BIT]) &&
			settings.watchdog_hw_enable == !$past(nv_byte1[obcd_pkg::WDT_BIT]);
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog type decode wrong"); // R4

	// Field and byte count both follow the stored field
	property p_sector;
		$rose(r.captured) |->
			settings.sector0_size_field == $past(nv_byte0[obcd_pkg::SSZ_HI:obcd_pkg::SSZ_LO]) &&
			settings.sector0_bytes ==
			(obcd_pkg::SEC0_BASE << $past(nv_byte0[obcd_pkg::SSZ_HI:obcd_pkg::SSZ_LO]));
	endproperty
	a_sector: assert property (p_sector) else $error("sector size decode wrong"); // R10

	property p_rdp;
		cmd.valid && r.sq == obcd_pkg::OBCD_SQ_IDLE && live_rdp &&
		(cmd.op == obcd_pkg::OBCD_OP_PM_RD || cmd.op == obcd_pkg::OBCD_OP_PM_WR)
		|=> rsp.refused && !pm.rd_ok && !pm.wr_ok;
	endproperty
	a_rdp: assert property (p_rdp) else $error("protected memory access granted"); // R11

	property p_wrp;
		cmd.valid && r.sq == obcd_pkg::OBCD_SQ_IDLE && live_wrp &&
		cmd.op == obcd_pkg::OBCD_OP_PM_ER |=> rsp.refused && !pm.er_ok;
	endproperty
	a_wrp: assert property (p_wrp) else $error("erase allowed under write protect"); // R14

	// Whole erase is requested before any byte is rewritten
	property p_mass_first;
		pm.mass_er |-> !nvw.wr && r.sq == obcd_pkg::OBCD_SQ_MASS;
	endproperty
	a_mass_first: assert property (p_mass_first) else $error("mass erase not first"); // R12

	// Erase finished, then both erased values in order
	sequence s_mass_end;
		r.sq == obcd_pkg::OBCD_SQ_MASS && mass_done;
	endsequence
	sequence s_restore;
		nvw.wr && nvw.addr == obcd_pkg::ADDR_CFG0 && nvw.data == obcd_pkg::CFG0_ERASED ##1
		nvw.wr && nvw.addr == obcd_pkg::ADDR_CFG1 && nvw.data == obcd_pkg::CFG1_ERASED && rsp.ack;
	endsequence
	property p_restore;
		s_mass_end |=> ##1 s_restore;
	endproperty
	a_restore: assert property (p_restore) else $error("erase restore sequence wrong"); // R18

	property p_fill;
		pm.fill == obcd_pkg::PM_ERASED;
	endproperty
	a_fill: assert property (p_fill) else $error("erase fill not all ones"); // R16

endmodule : obcd_config_decoder

//--- verification/obcd_prog_tool.sv
`timescale 1ns/10ps
// ****************************************
// Programming tool model
// ****************************************
module obcd_prog_tool (
	input  wire logic                mclk,
	input  wire obcd_pkg::obcd_rsp_t rsp,
	input  wire obcd_pkg::obcd_pm_t  pm,
	output obcd_pkg::obcd_cmd_t      cmd,
	output logic                     prog_mode_pin
);
	logic       ack;   // Last answer done
	logic       refd;  // Last answer refused
	logic       grant; // Memory grant seen
	logic       mass;  // Whole erase seen
	logic [7:0] rdata; // Last read data

	// Idle at time zero
	initial begin
		cmd = '0;
		prog_mode_pin = 1'h0;
	end

	// Mode pin is set, then held four cycles before the next access
	task automatic mode(input logic on);
		@(posedge mclk);
		prog_mode_pin <= on;
		repeat (4) @(posedge mclk);
	endtask : mode

	// One command, held one cycle, then wait for its answer
	task automatic access(input obcd_pkg::obcd_op_t op, input logic a, input logic [7:0] d);
		logic [7:0] w;
		w = d;
		if (op == obcd_pkg::OBCD_OP_CFG_WR && a) w[5:3] = 3'h7;
		if (op == obcd_pkg::OBCD_OP_CFG_WR && !a && !w[7]) w[6:4] = obcd_pkg::RNG_SLOW;
		grant = 1'h0;
		mass = 1'h0;
		@(posedge mclk);
		cmd <= '{1'h1, op, a, w};
		@(posedge mclk);
		cmd.valid <= 1'h0;
		for (int i = 0; i < 40; i++) begin
			#1;
			grant |= pm.rd_ok | pm.wr_ok | pm.er_ok;
			mass |= pm.mass_er;
			if (rsp.ack | rsp.refused) break;
			@(posedge mclk);
		end
		ack = rsp.ack;
		refd = rsp.refused;
		rdata = rsp.rdata;
	endtask : access
endmodule : obcd_prog_tool

//--- verification/option_byte_config_decoder_test.sv
`timescale 1ns/10ps
// ****************************************
// Decoder bench
// ****************************************
module option_byte_config_decoder_test;
	logic                mclk;      // Clock
	logic                rst_n;     // Reset, active low
	logic                prog_mode; // Mode pin
	logic                mass_done; // Whole erase done
	logic [7:0]          nv_byte0;  // Stored byte zero
	logic [7:0]          nv_byte1;  // Stored byte one
	int                  mcnt;      // Erase time left
	int                  fail_count;
	int                  n_tests;
	obcd_pkg::obcd_cmd_t cmd;
	obcd_pkg::obcd_rsp_t rsp;
	obcd_pkg::obcd_nvw_t nvw;
	obcd_pkg::obcd_pm_t  pm;
	obcd_pkg::obcd_set_t settings;
	// Byte pairs; internal-RC rows keep defaults
	logic [15:0]         vec [4] = '{16'hFC3F, 16'hC47A, 16'h47BD, 16'hB2FB};

	initial mclk = 1'h0;
	always #10 mclk = ~mclk;

	obcd_config_decoder u_obcd_config_decoder (
		.mclk(mclk), .rst_n(rst_n), .prog_mode_pin(prog_mode), .nv_byte0(nv_byte0),
		.nv_byte1(nv_byte1), .mass_done(mass_done), .cmd(cmd), .rsp(rsp), .nvw(nvw),
		.pm(pm), .settings(settings)
	);
	obcd_prog_tool u_obcd_prog_tool (
		.mclk(mclk), .rsp(rsp), .pm(pm), .cmd(cmd), .prog_mode_pin(prog_mode)
	);

	// Stored bytes and whole-memory erase timing
	always @(posedge mclk) begin
		if (nvw.wr === 1'h1) begin
			if (nvw.addr) nv_byte1 <= nvw.data;
			else nv_byte0 <= nvw.data;
		end
		mass_done <= (mcnt == 1);
		if (pm.mass_er === 1'h1) mcnt <= 4;
		else if (mcnt != 0) mcnt <= mcnt - 1;
	end

	// Expected decode of a byte pair
	function automatic logic [27:0] dec(input logic [7:0] b0, input logic [7:0] b1);
		return {b1[7:6], b1[7], b0[6:4], b0[7], b1[2], b1[1], ~b1[1], b1[0], b0[3:2],
			13'h200 << b0[3:2], b0[1], b0[0]};
	endfunction : dec

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize;
		if (fail_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	// Reset with given stored bytes
	task automatic restart(input logic [7:0] b0, input logic [7:0] b1);
		@(posedge mclk);
		nv_byte0 <= b0;
		nv_byte1 <= b1;
		rst_n <= 1'h0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (3) @(posedge mclk);
	endtask : restart

	// Command and compare {done, refused, grant}
	task automatic act(input obcd_pkg::obcd_op_t op, input logic a, input logic [7:0] d,
		input logic [2:0] exp);
		u_obcd_prog_tool.access(op, a, d);
		check({u_obcd_prog_tool.ack, u_obcd_prog_tool.refd, u_obcd_prog_tool.grant}, exp);
	endtask : act

	// Hang guard
	initial begin
		#100000;
		fail_count++;
		summarize();
	end

	// Main sequence
	initial begin
		rst_n = 1'h0;
		mass_done = 1'h0;
		mcnt = 0;
		nv_byte0 = 8'hFC;
		nv_byte1 = 8'h3F;
		fail_count = 0;
		n_tests = 0;
		foreach (vec[i]) begin
			restart(vec[i][15:8], vec[i][7:0]);
			check(settings, dec(vec[i][15:8], vec[i][7:0]));
		end
		restart(8'hFC, 8'h3F);
		act(obcd_pkg::OBCD_OP_CFG_RD, 1'h1, 8'h0, 3'h2);
		u_obcd_prog_tool.mode(1'h1);
		act(obcd_pkg::OBCD_OP_CFG_RD, 1'h1, 8'h0, 3'h4);
		check(u_obcd_prog_tool.rdata, 8'h3F);
		act(obcd_pkg::OBCD_OP_PM_RD, 1'h0, 8'h0, 3'h5);
		check(pm.fill, 8'hFF);
		act(obcd_pkg::OBCD_OP_PM_WR, 1'h0, 8'h0, 3'h5);
		act(obcd_pkg::OBCD_OP_CFG_ER, 1'h0, 8'h0, 3'h4);
		check(u_obcd_prog_tool.mass, 1'h0);
		act(obcd_pkg::OBCD_OP_CFG_WR, 1'h0, 8'hFD, 3'h4);
		act(obcd_pkg::OBCD_OP_CFG_RD, 1'h0, 8'h0, 3'h4);
		check(u_obcd_prog_tool.rdata, 8'hFD);
		check(settings, dec(8'hFC, 8'h3F));
		act(obcd_pkg::OBCD_OP_PM_WR, 1'h0, 8'h0, 3'h2);
		act(obcd_pkg::OBCD_OP_PM_ER, 1'h0, 8'h0, 3'h2);
		act(obcd_pkg::OBCD_OP_CFG_ER, 1'h0, 8'h0, 3'h2);
		act(obcd_pkg::OBCD_OP_CFG_WR, 1'h0, 8'hFC, 3'h2);
		act(obcd_pkg::OBCD_OP_CFG_WR, 1'h1, 8'h06, 3'h4);
		@(posedge mclk);
		@(negedge mclk);
		check(nv_byte1, 8'h3E);
		restart(8'hFE, 8'h3F);
		act(obcd_pkg::OBCD_OP_PM_RD, 1'h0, 8'h0, 3'h2);
		act(obcd_pkg::OBCD_OP_PM_WR, 1'h0, 8'h0, 3'h2);
		act(obcd_pkg::OBCD_OP_PM_ER, 1'h0, 8'h0, 3'h5);
		act(obcd_pkg::OBCD_OP_CFG_ER, 1'h0, 8'h0, 3'h4);
		check(u_obcd_prog_tool.mass, 1'h1);
		check({nv_byte0, nv_byte1}, 16'hFC3F);
		act(obcd_pkg::OBCD_OP_PM_RD, 1'h0, 8'h0, 3'h5);
		act(obcd_pkg::OBCD_OP_CFG_WR, 1'h0, 8'h0C, 3'h4);
		@(posedge mclk);
		@(negedge mclk);
		check(nv_byte0, 8'h4C);
		summarize();
	end
endmodule : option_byte_config_decoder_test
